/* tlwh_pkg.sv */
// package: constants, types and register map of the temperature loop word handshake
package tlwh_pkg;

  // ****************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0]  ADR_OUT_WORD = 8'h00; // host command / data word
  localparam logic [7:0]  ADR_IN_WORD  = 8'h04; // device answer word
  localparam logic [7:0]  ADR_CONFIG   = 8'h08; // switches: type, unit, encoding
  localparam logic [7:0]  ADR_STATUS   = 8'h0C; // per loop state flags
  localparam logic [9:0]  CONFIG_RST   = 10'h000; // celsius, binary, code 0
  localparam int          CFG_FAHR_BIT = 8;     // unit select bit
  localparam int          CFG_BCD_BIT  = 9;     // encoding select bit

  // ****************************************************************
  // command word layout and codes
  // ****************************************************************
  localparam logic [3:0]  PFX_IO_ALLOC = 4'hC;  // i/o allocation command
  localparam logic [3:0]  PFX_OP_CTRL  = 4'hA;  // operation control command
  localparam logic [3:0]  OP_STOP      = 4'h0;
  localparam logic [3:0]  OP_RUN       = 4'h1;
  localparam logic [3:0]  OP_AUTO      = 4'h2;
  localparam logic [3:0]  OP_MANUAL    = 4'h3;
  localparam logic [3:0]  OP_AUTOTUNE  = 4'h4;  // autotune_start_cmd
  localparam logic [3:0]  ITEM_SP      = 4'h0;  // set point
  localparam logic [3:0]  ITEM_SHIFT   = 4'h6;  // input shift value
  localparam logic [3:0]  ITEM_PV      = 4'h7;  // process value / no item set
  localparam logic [3:0]  ITEM_MV      = 4'h8;  // manipulated variable
  localparam logic [3:0]  ITEM_STAT    = 4'h9;  // status
  localparam logic [3:0]  ITEM_HBA     = 4'hA;  // heater alarm set value
  localparam logic [3:0]  ITEM_CT      = 4'hB;  // heater current
  localparam logic [15:0] CODE_SENSOR  = 16'hE400;
  localparam logic [15:0] CODE_CT_ERR  = 16'hE500;
  localparam logic [15:0] CODE_SET_ERR = 16'hEE01;

  // ****************************************************************
  // ranges in native units (tenths or hundredths)
  // ****************************************************************
  localparam logic signed [19:0] LIM_C_LO   = -20'sd2000;  // -200.0 / -20.00
  localparam logic signed [19:0] LIM_C_HI   = 20'sd6500;   // 650.0
  localparam logic signed [19:0] LIM_F_LO   = -20'sd3000;  // -300.0
  localparam logic signed [19:0] LIM_F_HI   = 20'sd12000;  // 1200.0
  localparam logic signed [19:0] LIM_H_HI   = 20'sd25000;  // 250.00
  localparam logic signed [19:0] MARGIN_T   = 20'sd200;    // 20 deg in tenths
  localparam logic signed [19:0] MARGIN_H   = 20'sd2000;   // 20 deg in hundredths
  localparam logic signed [19:0] BCD_LO     = -20'sd999;   // -99.9 / -9.99
  localparam logic signed [19:0] BCD_HI     = 20'sd9999;   // 999.9 / 99.99
  localparam logic [15:0]        HB_OFF     = 16'd0;       // 0.0 A
  localparam logic [15:0]        HB_FORCE   = 16'd500;     // 50.0 A
  localparam logic [15:0]        CT_LIMIT   = 16'd550;     // 55.0 A

  // ****************************************************************
  // parameter defaults per item index 11..0
  // ****************************************************************
  localparam logic [11:0][15:0] PARAM_RST = {16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0,
                                             16'd0, 16'd20, 16'd8, 16'd40, 16'd240,
                                             16'd400};

  // ****************************************************************
  // time proportional output timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS = 10;   // 100 MHz
  localparam int          TP_TICK_US    = 10;   // one step of the output ratio
  localparam logic [9:0]  TP_TICK_CYC   = 10'(TP_TICK_US * 1000 / CLK_PERIOD_NS);
  localparam logic [9:0]  TP_STEPS      = 10'd1000; // 0.1 % resolution

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_WAIT_DATA = 2'b01} tlwh_hs_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tlwh_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tlwh_wb_rsp_s;

  typedef struct packed {
    logic [15:0] meas;      // measured temperature, native units, signed
    logic [15:0] ct;        // heater current in 0.1 A
    logic [15:0] auto_mv;   // automatic output level in 0.1 %
    logic        auto_out;  // automatic control output
    logic        at_done;   // autotune run complete pulse
  } tlwh_loop_in_s;

endpackage

/* tlwh_core.sv */
// module: word handshake, encodings and alarms of a four loop temperature controller
`timescale 1ns/10ps
// Behaviour
// - codes 0/1 celsius binary: tenths, F830..1964
// - codes 2/3 celsius binary: hundredths; no fahrenheit
// - codes 0/1 fahrenheit binary: tenths, F448..2EE0
// - bcd: four digits, leading F means negative
// - indicate within setting range plus twenty degrees
// - beyond indication: E400, auto output forced off
// - bcd clamps to -99.9..999.9 or -9.99..99.99
// - type change clamps set points to range
// - type change rescales set point and shift decimals
// - manual keeps last automatic level, time proportional
// - burnout alarm latched; cleared by set 0.0
// - set 0.1..49.9 is burnout current threshold
// - set 50.0 forces alarm on, no detection
// - current 55.0 A raises error, reports E500
// - indicated value is measurement plus shift
// - autotuning loop refuses parameter writes
// - autotune start left in word restarts
// - power on: auto mode, stopped until commanded
// - allocation command acknowledged by echo
// - data applied, then monitor item signals completion
// - unknown item code reports EE01
module tlwh_core (
  input  wire logic                             clk_i,       // unit clock
  input  wire logic                             rst_i,       // sync reset, high
  input  wire tlwh_pkg::tlwh_wb_req_s           wb_i,        // wishbone request
  output tlwh_pkg::tlwh_wb_rsp_s                wb_o,        // wishbone answer
  input  wire tlwh_pkg::tlwh_loop_in_s [3:0]    loop_i,      // front end per loop
  output logic [3:0]                            ctrl_out_o,  // control outputs
  output logic [3:0]                            autotune_o,  // autotune running
  output logic                                  heater_alarm_out_a_o, // loops 1, 3
  output logic                                  heater_alarm_out_b_o  // loops 2, 4
);
  import tlwh_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    tlwh_hs_e               hs;        // handshake step
    logic [15:0]            out_word;  // last host word
    logic [15:0]            in_word;   // answer word
    logic [15:0]            cmd;       // accepted allocation command
    logic [9:0]             cfg;       // input_type_switch, unit, encoding
    logic [3:0]             run;       // loop running
    logic [3:0]             man;       // loop in manual mode
    logic [3:0]             at;        // autotune in progress
    logic [3:0]             alarm;     // latched burnout alarms
    logic [3:0]             ctrl;      // control outputs
    logic [3:0]             sens;      // sensor error per loop
    logic [3:0]             ct_err;    // current input error per loop
    logic [3:0][11:0][15:0] param;     // stored items per loop
    logic [9:0]             tp_div;    // clock divider for ratio steps
    logic [9:0]             tp_cnt;    // ratio step counter
    logic                   wb_ack;    // bus acknowledge
    logic [31:0]            wb_dat;    // bus read data
    logic                   hb_a;      // alarm output a
    logic                   hb_b;      // alarm output b
  } tlwh_state_s;

  tlwh_state_s s_r;    // registered state
  tlwh_state_s s_nxt;  // next state

  // ****************************************************************
  // helpers
  // ****************************************************************
  // range code of a loop: loops 1/3 low nibble, loops 2/4 high nibble
  function automatic logic [3:0] fn_code(input logic [9:0] cfg, input int l);
    fn_code = l[0] ? cfg[7:4] : cfg[3:0];
  endfunction

  // hundredths ranges are codes 2 and 3
  function automatic logic fn_hund(input logic [3:0] code);
    fn_hund = (code == 4'h2) || (code == 4'h3);
  endfunction

  // lower setting limit; same figure for both celsius resolutions
  function automatic logic signed [19:0] fn_lo(input logic [3:0] code, input logic fahr);
    fn_lo = (!fn_hund(code) && fahr) ? LIM_F_LO : LIM_C_LO;
  endfunction

  // upper setting limit; fahrenheit is ignored on hundredths ranges
  function automatic logic signed [19:0] fn_hi(input logic [3:0] code, input logic fahr);
    if (fn_hund(code)) begin
      fn_hi = LIM_H_HI;
    end else begin
      fn_hi = fahr ? LIM_F_HI : LIM_C_HI;
    end
  endfunction

  function automatic logic signed [19:0] fn_clamp(input logic signed [19:0] v,
                                                  input logic signed [19:0] lo,
                                                  input logic signed [19:0] hi);
    if (v < lo) begin
      fn_clamp = lo;
    end else if (v > hi) begin
      fn_clamp = hi;
    end else begin
      fn_clamp = v;
    end
  endfunction

  // signed native value to four bcd digits, F nibble for negatives
  function automatic logic [15:0] fn_to_bcd(input logic signed [19:0] v);
    logic        neg;
    logic [19:0] m;
    neg = v < 0;
    m   = neg ? 20'(-v) : 20'(v);
    if (m > 20'd9999) begin
      m = 20'd9999;
    end
    fn_to_bcd = {neg ? 4'hF : 4'(m / 20'd1000), 4'((m / 20'd100) % 20'd10),
                 4'((m / 20'd10) % 20'd10), 4'(m % 20'd10)};
  endfunction

  // four bcd digits back to a signed native value
  function automatic logic signed [19:0] fn_from_bcd(input logic [15:0] w);
    logic        neg;
    logic [19:0] m;
    neg = w[15:12] == 4'hF;
    m   = (neg ? 20'd0 : 20'(w[15:12]) * 20'd1000) + 20'(w[11:8]) * 20'd100
          + 20'(w[7:4]) * 20'd10 + 20'(w[3:0]);
    fn_from_bcd = neg ? -20'(signed'(m)) : 20'(signed'(m));
  endfunction

  function automatic logic signed [19:0] fn_sext(input logic [15:0] w);
    fn_sext = {{4{w[15]}}, w};
  endfunction

  // ****************************************************************
  // next state logic
  // ****************************************************************
  always_comb begin
    logic                   bcd;      // bcd encoding selected
    logic                   fahr;     // fahrenheit selected
    logic                   req;      // new bus request
    logic                   wr;       // bus write commits this edge
    logic [15:0]            w;        // merged out word
    logic [9:0]             c;        // merged config
    logic [1:0]             li;       // loop index from a command
    logic [3:0]             code;     // range code
    logic [3:0]             mi;       // monitor item
    logic signed [19:0]     lo;       // setting range low
    logic signed [19:0]     hi;       // setting range high
    logic signed [19:0]     marg;     // indication margin
    logic signed [19:0]     v;        // scratch value
    logic                   raw;      // monitor value is a code
    logic                   set_ok;   // set item is defined
    bcd    = s_r.cfg[CFG_BCD_BIT];
    fahr   = s_r.cfg[CFG_FAHR_BIT];
    req    = wb_i.cyc && wb_i.stb && !s_r.wb_ack;
    wr     = wb_i.cyc && wb_i.stb && wb_i.we && s_r.wb_ack;
    w      = s_r.out_word;
    c      = s_r.cfg;
    li     = 2'b00;
    code   = 4'h0;
    mi     = 4'h0;
    lo     = '0;
    hi     = '0;
    marg   = '0;
    v      = '0;
    raw    = 1'b0;
    set_ok = 1'b0;
    s_nxt  = s_r;

    // ratio step divider: one enable pulse per step
    s_nxt.tp_div = (s_r.tp_div == TP_TICK_CYC - 10'd1) ? 10'd0 : s_r.tp_div + 10'd1;
    if (s_r.tp_div == TP_TICK_CYC - 10'd1) begin
      s_nxt.tp_cnt = (s_r.tp_cnt == TP_STEPS - 10'd1) ? 10'd0 : s_r.tp_cnt + 10'd1;
    end

    // per loop measurement, errors, alarms and outputs
    for (int l = 0; l < 4; l++) begin
      code = fn_code(s_r.cfg, l);
      lo   = fn_lo(code, fahr);
      hi   = fn_hi(code, fahr);
      marg = fn_hund(code) ? MARGIN_H : MARGIN_T;
      v    = fn_sext(loop_i[l].meas) + fn_sext(s_r.param[l][ITEM_SHIFT]);
      s_nxt.sens[l] = (v < lo - marg) || (v > hi + marg);
      s_nxt.ct_err[l] = loop_i[l].ct >= CT_LIMIT;
      // burnout alarm: off at 0.0, forced at 50.0, latched otherwise
      // the latch only falls through a zero set value, never by itself
      if (s_r.param[l][ITEM_HBA] == HB_OFF) begin
        s_nxt.alarm[l] = 1'b0;
      end else if (s_r.param[l][ITEM_HBA] >= HB_FORCE) begin
        s_nxt.alarm[l] = 1'b1;
      end else if (s_r.run[l] && s_r.ctrl[l] && loop_i[l].ct < s_r.param[l][ITEM_HBA]) begin
        s_nxt.alarm[l] = 1'b1;
      end
      // control output: stopped loops stay off
      if (!s_r.run[l]) begin
        s_nxt.ctrl[l] = 1'b0;
      end else if (s_r.man[l]) begin
        s_nxt.ctrl[l] = 16'(s_r.tp_cnt) < s_r.param[l][ITEM_MV];
      end else begin
        s_nxt.ctrl[l] = loop_i[l].auto_out && !s_nxt.sens[l];
      end
      // end of autotune; a start word still standing starts a new run
      if (s_r.at[l] && loop_i[l].at_done) begin
        s_nxt.at[l] = s_r.out_word == {PFX_OP_CTRL, OP_AUTOTUNE, 4'h0, 4'(l + 1)};
      end
    end

    // ****************************************************************
    // wishbone slave: ack one cycle after the request, writes at ack edge
    // ****************************************************************
    // a master that keeps stb up after ack is taken as a new request one cycle later
    s_nxt.wb_ack = req;
    if (req) begin
      case (wb_i.adr)
        ADR_OUT_WORD: s_nxt.wb_dat = {16'h0000, s_r.out_word};
        ADR_IN_WORD:  s_nxt.wb_dat = {16'h0000, s_r.in_word};
        ADR_CONFIG:   s_nxt.wb_dat = {22'h000000, s_r.cfg};
        ADR_STATUS:   s_nxt.wb_dat = {8'h00, s_r.alarm, s_r.ct_err, s_r.sens,
                                      s_r.at, s_r.man, s_r.run};
        default:      s_nxt.wb_dat = 32'h00000000;  // unmapped reads as zero
      endcase
    end

    // ****************************************************************
    // config write: new ranges rescale and clamp stored values
    // ****************************************************************
    if (wr && wb_i.adr == ADR_CONFIG) begin
      c[7:0] = wb_i.sel[0] ? wb_i.dat[7:0] : s_r.cfg[7:0];
      c[9:8] = wb_i.sel[1] ? wb_i.dat[9:8] : s_r.cfg[9:8];
      s_nxt.cfg = c;
      for (int l = 0; l < 4; l++) begin
        code = fn_code(c, l);
        if (code != fn_code(s_r.cfg, l)) begin
          // decimal point follows the new range
          v = fn_sext(s_r.param[l][ITEM_SP]);
          if (fn_hund(code) && !fn_hund(fn_code(s_r.cfg, l))) begin
            v = v * 20'sd10;
            s_nxt.param[l][ITEM_SHIFT] = 16'(fn_clamp(
              fn_sext(s_r.param[l][ITEM_SHIFT]) * 20'sd10, BCD_LO, BCD_HI));
          end else if (!fn_hund(code) && fn_hund(fn_code(s_r.cfg, l))) begin
            v = v / 20'sd10;
            s_nxt.param[l][ITEM_SHIFT] = 16'(fn_sext(s_r.param[l][ITEM_SHIFT]) / 20'sd10);
          end
          s_nxt.param[l][ITEM_SP] = 16'(fn_clamp(v, fn_lo(code, c[CFG_FAHR_BIT]),
                                                 fn_hi(code, c[CFG_FAHR_BIT])));
        end
      end
    end

    // ****************************************************************
    // out word write: command handshake
    // ****************************************************************
    if (wr && wb_i.adr == ADR_OUT_WORD) begin
      w[7:0]  = wb_i.sel[0] ? wb_i.dat[7:0]  : s_r.out_word[7:0];
      w[15:8] = wb_i.sel[1] ? wb_i.dat[15:8] : s_r.out_word[15:8];
      s_nxt.out_word = w;
      li = 2'(w[3:0] - 4'h1);
      case (s_r.hs)
        HS_IDLE: begin
          set_ok = (w[11:8] <= ITEM_MV) || (w[11:8] == ITEM_HBA);
          if (w[15:12] == PFX_IO_ALLOC) begin
            if (set_ok && w[7:4] <= ITEM_CT && w[3:0] >= 4'h1 && w[3:0] <= 4'h4) begin
              s_nxt.in_word = w;
              s_nxt.cmd     = w;
              s_nxt.hs      = HS_WAIT_DATA;
            end else begin
              s_nxt.in_word = CODE_SET_ERR;
            end
          end else if (w[15:12] == PFX_OP_CTRL) begin
            if (w[11:8] <= OP_AUTOTUNE && w[3:0] >= 4'h1 && w[3:0] <= 4'h4) begin
              s_nxt.in_word = w;
              case (w[11:8])
                OP_STOP:   s_nxt.run[li] = 1'b0;
                OP_RUN:    s_nxt.run[li] = 1'b1;
                OP_AUTO:   s_nxt.man[li] = 1'b0;
                OP_MANUAL: begin
                  if (!s_r.man[li]) begin
                    s_nxt.param[li][ITEM_MV] = loop_i[li].auto_mv;
                  end
                  s_nxt.man[li] = 1'b1;
                end
                default:   s_nxt.at[li] = 1'b1;
              endcase
            end else begin
              s_nxt.in_word = CODE_SET_ERR;
            end
          end
          // any other word leaves the answer untouched
        end
        HS_WAIT_DATA: begin
          // data phase: always belongs to the last accepted command
          li = 2'(s_r.cmd[3:0] - 4'h1);
          // a tuning loop keeps its parameters; the answer is still given
          if (!s_r.at[li] && s_r.cmd[11:8] != ITEM_PV) begin
            v = bcd ? fn_from_bcd(w) : fn_sext(w);
            if (s_r.cmd[11:8] == ITEM_SP) begin
              code = fn_code(s_r.cfg, int'(li));
              v    = fn_clamp(v, fn_lo(code, fahr), fn_hi(code, fahr));
            end
            s_nxt.param[li][s_r.cmd[11:8]] = 16'(v);
          end
          // completion answer: selected monitor item after the write
          mi = s_r.cmd[7:4];
          case (mi)
            ITEM_PV: begin
              // recomputed with the shift just written, so the answer shows it
              code = fn_code(s_r.cfg, int'(li));
              lo   = fn_lo(code, fahr);
              hi   = fn_hi(code, fahr);
              marg = fn_hund(code) ? MARGIN_H : MARGIN_T;
              v    = fn_sext(loop_i[li].meas) + fn_sext(s_nxt.param[li][ITEM_SHIFT]);
              raw  = (v < lo - marg) || (v > hi + marg);
              if (raw) begin
                v = fn_sext(CODE_SENSOR);
              end else if (bcd) begin
                v = fn_clamp(v, BCD_LO, BCD_HI);
              end
            end
            ITEM_MV: begin
              v = fn_sext(s_r.man[li] ? s_nxt.param[li][ITEM_MV] : loop_i[li].auto_mv);
            end
            ITEM_STAT: begin
              raw = 1'b1;
              v   = 20'({s_r.alarm[li], s_r.ct_err[li], s_r.sens[li],
                          s_r.at[li], s_r.man[li], s_r.run[li]});
            end
            ITEM_CT: begin
              raw = s_nxt.ct_err[li];
              v   = fn_sext(raw ? CODE_CT_ERR : loop_i[li].ct);
            end
            default: begin
              v = fn_sext(s_nxt.param[li][mi]);
            end
          endcase
          s_nxt.in_word = (bcd && !raw) ? fn_to_bcd(v) : 16'(v);
          s_nxt.hs      = HS_IDLE;
        end
        default: begin
          s_nxt.hs = HS_IDLE;
        end
      endcase
    end

    // alarm outputs follow the latches of their loop pair
    s_nxt.hb_a = s_nxt.alarm[0] || s_nxt.alarm[2];
    s_nxt.hb_b = s_nxt.alarm[1] || s_nxt.alarm[3];
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r          <= '0;           // auto mode, all loops stopped
      s_r.hs       <= HS_IDLE;
      s_r.cfg      <= CONFIG_RST;
      for (int l = 0; l < 4; l++) begin
        s_r.param[l] <= PARAM_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs straight from the state register
  // ****************************************************************
  assign wb_o.ack             = s_r.wb_ack;
  assign wb_o.dat             = s_r.wb_dat;
  assign ctrl_out_o           = s_r.ctrl;
  assign autotune_o           = s_r.at;
  assign heater_alarm_out_a_o = s_r.hb_a;
  assign heater_alarm_out_b_o = s_r.hb_b;

endmodule // tlwh_core

/* tlwh_core_props.sv */
// checker: bus timing and output causes
`timescale 1ns/10ps
module tlwh_core_chk (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire tlwh_pkg::tlwh_wb_req_s wb_i,
  input wire tlwh_pkg::tlwh_wb_rsp_s wb_o,
  input wire logic [3:0]            ctrl_out_o,
  input wire logic [3:0]            autotune_o,
  input wire logic                  heater_alarm_out_a_o
);
  import tlwh_pkg::*;
  logic req, wr, seen_r; // open request, accepted write, any write since reset
  assign req = wb_i.cyc & wb_i.stb & ~wb_o.ack;
  assign wr = wb_o.ack & wb_i.we;
  always_ff @(posedge clk_i) seen_r <= rst_i ? 1'b0 : (seen_r | wr);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd(a); req && !wb_i.we && wb_i.adr == a; endsequence
  sequence s_quiet; !wb_i.cyc [*3]; endsequence
  property p_ack_lat; req |=> wb_o.ack; endproperty
  property p_ack_pulse; wb_o.ack |=> !wb_o.ack; endproperty
  property p_ack_cause; $rose(wb_o.ack) |-> $past(req); endproperty
  property p_unmapped; s_rd(8'h10) |=> wb_o.dat == 32'h0; endproperty
  property p_in_hi; s_rd(ADR_IN_WORD) |=> wb_o.dat[31:16] == 16'h0; endproperty
  property p_idle; !seen_r |-> {ctrl_out_o, autotune_o, heater_alarm_out_a_o} == 9'h0;
  endproperty
  property p_at_start; $rose(autotune_o[0]) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
  endproperty
  property p_alarm_hold; s_quiet ##0 heater_alarm_out_a_o |=> heater_alarm_out_a_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
  a_in_hi: assert property (p_in_hi) else $error("word upper bits");
  a_idle: assert property (p_idle) else $error("active before command");
  a_at_start: assert property (p_at_start) else $error("tune without write");
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped");
endmodule // tlwh_core_chk
bind tlwh_core tlwh_core_chk i_tlwh_core_chk (.clk_i, .rst_i, .wb_i, .wb_o, .ctrl_out_o,
  .autotune_o, .heater_alarm_out_a_o);

/* tlwh_front_model.sv */
// model: loop front end; a tuning run ends after 20 cycles
`timescale 1ns/10ps
module tlwh_front_model (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [15:0]              meas_i,     // temperature, all loops
  input  wire logic [15:0]              ct_i,       // heater current, all loops
  input  wire logic                     auto_out_i, // pid output, all loops
  input  wire logic [3:0]               autotune_i, // runs in progress
  output tlwh_pkg::tlwh_loop_in_s [3:0] loop_o
);
  import tlwh_pkg::*;
  logic [4:0] run_r; // cycles into the run
  always_ff @(posedge clk_i) begin
    run_r <= (rst_i || autotune_i == 4'h0 || run_r == 5'd20) ? 5'd0 : run_r + 5'd1;
  end
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      loop_o[l] = '{meas_i, ct_i, 16'd500, auto_out_i, autotune_i[l] && run_r == 5'd20};
    end
  end
endmodule // tlwh_front_model

/* tlwh_tb.sv */
// testbench: handshake scenarios over the register bus
`timescale 1ns/10ps
module tb;
  import tlwh_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, alarm_a, alarm_b;
  logic [15:0] meas = 16'h0100, ct = 16'h0064;
  tlwh_wb_req_s wb_r = '0;
  tlwh_wb_rsp_s wb_o;
  tlwh_loop_in_s [3:0] loop;
  logic [3:0] ctrl, at;
  logic [31:0] q;
  int miscompares = 0, total_checks = 0;
  logic [31:0] rows [0:9] = '{32'hC071C071, 32'h012C0100, 32'hC0F1EE01, 32'hC671C671,
    32'h001E011E, 32'hC771C771, 32'h0000011E, 32'hCAB1CAB1, 32'h01F40064, 32'hA101A101};
  always #5 clk_i = ~clk_i;
  tlwh_front_model i_tlwh_front_model (.clk_i, .rst_i, .meas_i(meas), .ct_i(ct),
    .auto_out_i(1'b1), .autotune_i(at), .loop_o(loop));
  tlwh_core i_tlwh_core (.clk_i, .rst_i, .wb_i(wb_r), .wb_o, .loop_i(loop), .ctrl_out_o(ctrl),
    .autotune_o(at), .heater_alarm_out_a_o(alarm_a), .heater_alarm_out_b_o(alarm_b));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_r <= '{1'b1, 1'b1, we, a, 4'h3, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 50);
    q = wb_o.dat;
    wb_r <= '0;
    if (wb_o.ack !== 1'b1) begin
      miscompares++;
      close_out();
    end
  endtask
  // output word written, input word read back
  task automatic hs(input logic [15:0] w, input logic [15:0] e);
    wb(1'b1, ADR_OUT_WORD, {16'h0, w});
    wb(1'b0, ADR_IN_WORD, 32'h0);
    chk(q, {16'h0, e});
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({ctrl, at, alarm_a, alarm_b}, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 10; i++) hs(rows[i][31:16], rows[i][15:0]);
    $display("row tests done");
    repeat (5) @(posedge clk_i);
    chk({ctrl[0], alarm_a}, 2'b11);
    meas <= 16'h2000;
    hs(16'hC771, 16'hC771);
    hs(16'h0000, 16'hE400);
    chk(ctrl[0], 1'b0);
    ct <= 16'h0226;
    hs(16'hCAB1, 16'hCAB1);
    hs(16'h0000, 16'hE500);
    chk(alarm_a, 1'b0);
    meas <= 16'hFA24;
    wb(1'b1, ADR_CONFIG, 32'h200);
    hs(16'hC771, 16'hC771);
    hs(16'h0000, 16'hF999);
    hs(16'hA401, 16'hA401);
    repeat (40) @(posedge clk_i);
    chk(at[0], 1'b1);
    hs(16'hC001, 16'hC001);
    hs(16'h0050, 16'h0300);
    repeat (25) @(posedge clk_i);
    chk(at[0], 1'b0);
    $display("awkward tests done");
    close_out();
  end
endmodule // tb
